// file: mtr_pkg.sv
// Purpose: shared constants and types for the multichannel temperature readout
// Assumes: one clock, synchronous active-high reset
// Notes: result word is 16-bit two's complement, lsb at bit 3
package mtr_pkg;
  localparam int MTR_NCH = 9;                       // local channel 0 plus eight remote
  localparam int MTR_RAW_W = 13;                    // significant result bits
  localparam int MTR_LSB_POS = 3;                   // position of one sixteenth degree
  localparam logic [15:0] MTR_MIN_CODE = 16'h8000;  // minus 256 degrees
  localparam logic [15:0] MTR_RES_RST = 16'h0000;
  localparam logic [15:0] MTR_LIM_RST = 16'h7FF8;   // limits start at the top of range
  localparam logic [15:0] MTR_HYST_RST = 16'h0000;
  localparam logic [3:0] MTR_LAST_CH = 4'h8;
  localparam logic [3:0] MTR_FIRST_CH = 4'h0;
  localparam int MTR_SYNC_N = 3;                    // flip-flops on the fault and short pin inputs
  typedef enum logic [1:0] {
    MTR_IDLE = 2'b00,
    MTR_CONV = 2'b01,
    MTR_STORE = 2'b11
  } mtr_state_e;
endpackage : mtr_pkg

// file: mtr_cmp_if.sv
// Purpose: carries one result, one limit and the hysteresis to the alert comparator
// Assumes: all signals on i_mclk
// Notes: two instances per channel, one per limit
interface mtr_cmp_if;
  logic [15:0] result;
  logic [15:0] limit;
  logic [15:0] hyst;
  logic alert;
  modport top (output result, output limit, output hyst, input alert);
  modport cmp (input result, input limit, input hyst, output alert);
endinterface : mtr_cmp_if

// file: mtr_alert_cmp.sv
// Purpose: hysteretic overtemperature comparator for one channel and one limit
// Assumes: signed 16-bit result and limit words
// Notes: alert holds until result drops below limit minus hysteresis
module mtr_alert_cmp
  import mtr_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // comparator carrier
  mtr_cmp_if.cmp c
);
  typedef struct packed {
    logic alert;
  } mtr_cmp_s;
  mtr_cmp_s st_q, st_d;
  logic signed [16:0] rel;

  // release point widened by one bit so a large hysteresis cannot wrap
  always_comb begin
    rel = 17'(signed'(c.limit)) - 17'(signed'(c.hyst));
    st_d = st_q;
    if (signed'(c.result) > signed'(c.limit)) begin
      st_d.alert = 1'b1;
    end else if (17'(signed'(c.result)) < rel) begin
      st_d.alert = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign c.alert = st_q.alert;

  a_alert_set: assert property (@(posedge i_mclk) disable iff (i_rst)
    signed'(c.result) > signed'(c.limit) |=> c.alert)
    else $error("alert did not set above limit");
  a_alert_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
    c.alert && (17'(signed'(c.result)) >= rel) |=> c.alert)
    else $error("alert released inside hysteresis band");
endmodule : mtr_alert_cmp

// file: mtr_readout.sv
// Purpose: result formatting, fault flags and alerts for nine temperature channels
// Assumes: converter delivers a 13-bit signed count per channel with a done strobe
// Notes: fault comparator and short detect are asynchronous pins, synchronised here
//
// How it works
// - results hold 13 bits, sixteenth degree each
// - negatives two's complement, positives plain binary
// - word spans minus 256 to 255.9375
// - high byte integer two degrees, low byte one degree plus fraction
// - count lsb at bit 3, low bits zero
// - shorted remote diode reads minus 256
// - miswire or open anode is a fault
// - comparator sampled during conversion sets open flag
// - two overtemperature alert outputs from limits
// - one shared hysteresis for both alerts
// - one local plus eight remote result words
// - shutdown finishes current conversion then stops
module mtr_readout
  import mtr_pkg::*;
#(
  parameter int NCH = MTR_NCH
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // control
  input wire logic i_shutdown_control_bit,
  input wire logic [15:0] i_hyst,
  input wire logic [NCH*16-1:0] i_limit1,
  input wire logic [NCH*16-1:0] i_limit2,
  input wire logic i_open_flag_clr,
  // converter side
  input wire logic i_conv_done,
  input wire logic [MTR_RAW_W-1:0] i_conv_count,
  input wire logic i_fault_cmp,
  input wire logic i_diode_short,
  // conversion control
  output logic o_conv_start,
  output logic [3:0] o_conv_ch,
  output logic o_busy,
  // results and status
  output logic [NCH*16-1:0] o_result,
  output logic [NCH-1:0] o_remote_open_flag,
  output logic o_overtemp_alert_n,
  output logic o_second_overtemp_alert_n
);
  typedef struct packed {
    mtr_state_e st;
    logic [3:0] ch;
    logic start;
    logic fault_seen;
    logic [MTR_SYNC_N-1:0] flt_sync;
    logic [MTR_SYNC_N-1:0] sht_sync;
    logic flt_val;
    logic sht_val;
    logic busy;
    logic [NCH*16-1:0] res;
    logic [NCH-1:0] open_flag;
    logic alert1_n;
    logic alert2_n;
  } mtr_top_s;
  mtr_top_s s_q, s_d;

  logic [NCH-1:0] a1, a2;
  logic fault_now, short_now;

  // change counts only once the last two sync stages agree;
  // while they differ the last agreed level is kept, so a
  // metastable stage can neither raise nor drop the level early
  assign fault_now = (s_q.flt_sync[1] == s_q.flt_sync[2]) ? s_q.flt_sync[2] : s_q.flt_val;
  assign short_now = (s_q.sht_sync[1] == s_q.sht_sync[2]) ? s_q.sht_sync[2] : s_q.sht_val;

  // per channel, two comparators sharing one hysteresis
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    mtr_cmp_if c1();
    mtr_cmp_if c2();
    assign c1.result = s_q.res[g*16 +: 16];
    assign c1.limit = i_limit1[g*16 +: 16];
    assign c1.hyst = i_hyst;
    assign c2.result = s_q.res[g*16 +: 16];
    assign c2.limit = i_limit2[g*16 +: 16];
    assign c2.hyst = i_hyst;
    assign a1[g] = c1.alert;
    assign a2[g] = c2.alert;
    mtr_alert_cmp u_c1 (.i_mclk(i_mclk), .i_rst(i_rst), .c(c1));
    mtr_alert_cmp u_c2 (.i_mclk(i_mclk), .i_rst(i_rst), .c(c2));
  end

  // formatting: place the 13 bits at bits 15 to 3, low three bits zero
  function automatic logic [15:0] fmt(input logic [MTR_RAW_W-1:0] cnt);
    logic [15:0] w;
    w = {cnt, 3'b000};
    return w;
  endfunction : fmt

  // sequencer, formatting and flag logic
  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.flt_sync = {s_q.flt_sync[MTR_SYNC_N-2:0], i_fault_cmp};
    s_d.sht_sync = {s_q.sht_sync[MTR_SYNC_N-2:0], i_diode_short};
    // remember the agreed pin levels
    s_d.flt_val = fault_now;
    s_d.sht_val = short_now;
    unique case (s_q.st)
      MTR_IDLE: begin
        // shutdown holds the sequencer here between conversions
        if (!i_shutdown_control_bit) begin
          s_d.st = MTR_CONV;
          s_d.start = 1'b1;
          s_d.fault_seen = 1'b0;
        end
      end
      MTR_CONV: begin
        // remote channels only; local has no diode comparator
        if (fault_now && s_q.ch != MTR_FIRST_CH) begin
          s_d.fault_seen = 1'b1;
        end
        if (i_conv_done) begin
          s_d.st = MTR_STORE;
          if (short_now && s_q.ch != MTR_FIRST_CH) begin
            s_d.res[s_q.ch*16 +: 16] = MTR_MIN_CODE;
          end else begin
            s_d.res[s_q.ch*16 +: 16] = fmt(i_conv_count);
          end
        end
      end
      MTR_STORE: begin
        // next channel wraps after the last remote
        s_d.ch = (s_q.ch == MTR_LAST_CH) ? MTR_FIRST_CH : s_q.ch + 4'h1;
        s_d.st = MTR_IDLE;
      end
      default: begin
        s_d.st = MTR_IDLE;
      end
    endcase
    // clear first, then a same-cycle fault wins
    if (i_open_flag_clr) begin
      s_d.open_flag = '0;
    end
    if (s_q.st == MTR_CONV && i_conv_done && (s_q.fault_seen || fault_now)
        && s_q.ch != MTR_FIRST_CH) begin
      s_d.open_flag[s_q.ch] = 1'b1;
    end
    // busy kept in a flop so the pin has no decode glitch
    s_d.busy = (s_d.st != MTR_IDLE);
    // any channel over its limit drives the alert low
    s_d.alert1_n = ~(|a1);
    s_d.alert2_n = ~(|a2);
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s_q <= '{st: MTR_IDLE, ch: MTR_FIRST_CH, start: 1'b0, fault_seen: 1'b0,
               flt_sync: '0, sht_sync: '0, flt_val: 1'b0, sht_val: 1'b0, busy: 1'b0,
               res: '0, open_flag: '0,
               alert1_n: 1'b1, alert2_n: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state flops
  assign o_conv_start = s_q.start;
  assign o_conv_ch = s_q.ch;
  assign o_busy = s_q.busy;
  assign o_result = s_q.res;
  assign o_remote_open_flag = s_q.open_flag;
  assign o_overtemp_alert_n = s_q.alert1_n;
  assign o_second_overtemp_alert_n = s_q.alert2_n;

  sequence s_done_remote;
    s_q.st == MTR_CONV && i_conv_done && s_q.ch != MTR_FIRST_CH;
  endsequence

  a_low_bits_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_conv_done && s_q.st == MTR_CONV |=> s_q.res[s_q.ch*16 +: 3] == 3'b000)
    else $error("result low bits not zero");
  a_short_min: assert property (@(posedge i_mclk) disable iff (i_rst)
    s_done_remote and short_now |=> s_q.res[$past(s_q.ch)*16 +: 16] == MTR_MIN_CODE)
    else $error("shorted channel not minimum code");
  a_open_set: assert property (@(posedge i_mclk) disable iff (i_rst)
    s_done_remote and fault_now |=> s_q.open_flag[$past(s_q.ch)])
    else $error("open flag not set on fault");
  a_shutdown_stop: assert property (@(posedge i_mclk) disable iff (i_rst)
    s_q.st == MTR_IDLE && i_shutdown_control_bit |=> !s_q.start)
    else $error("conversion started in shutdown");
  a_conv_resume: assert property (@(posedge i_mclk) disable iff (i_rst)
    s_q.st == MTR_IDLE && !i_shutdown_control_bit |=> s_q.start && s_q.st == MTR_CONV)
    else $error("continuous conversion did not start");
  a_sign_keep: assert property (@(posedge i_mclk) disable iff (i_rst)
    s_q.st == MTR_CONV && i_conv_done && !(short_now && s_q.ch != MTR_FIRST_CH)
    |=> s_q.res[$past(s_q.ch)*16 + 15] == $past(i_conv_count[MTR_RAW_W-1]))
    else $error("sign bit lost");
  a_alert_or: assert property (@(posedge i_mclk) disable iff (i_rst)
    (|a1) |=> !o_overtemp_alert_n)
    else $error("first alert not asserted");
  a_alert2_or: assert property (@(posedge i_mclk) disable iff (i_rst)
    !(|a2) |=> o_second_overtemp_alert_n)
    else $error("second alert not released");
  a_ch_wrap: assert property (@(posedge i_mclk) disable iff (i_rst)
    s_q.st == MTR_STORE && s_q.ch == MTR_LAST_CH |=> s_q.ch == MTR_FIRST_CH)
    else $error("channel did not wrap after last");

  // start is a single pulse and only while busy
  a_start_pulse: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_conv_start |=> !o_conv_start)
    else $error("start longer than one cycle");
  a_start_busy: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_conv_start |-> o_busy)
    else $error("start while not busy");

  // channel index never leaves the nine channels
  a_ch_range: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_conv_ch <= MTR_LAST_CH)
    else $error("channel index out of range");

  // the local channel has no diode, so its flag stays low
  a_local_flag: assert property (@(posedge i_mclk) disable iff (i_rst)
    !o_remote_open_flag[0])
    else $error("local channel open flag set");

  // a clear with no store in the same cycle empties every flag
  a_flag_clear: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_open_flag_clr && !(s_q.st == MTR_CONV && i_conv_done) |=> s_q.open_flag == '0)
    else $error("open flags not cleared");

  // flags are sticky until cleared
  a_flag_keep: assert property (@(posedge i_mclk) disable iff (i_rst)
    !i_open_flag_clr |=> (s_q.open_flag & $past(s_q.open_flag)) == $past(s_q.open_flag))
    else $error("open flag dropped without clear");

  // a done outside conversion must not touch stored results
  a_done_ignored: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_conv_done && s_q.st != MTR_CONV |=> $stable(s_q.res))
    else $error("result changed on stray done");

  // alerts come out of reset released
  a_alert_reset: assert property (@(posedge i_mclk)
    i_rst |=> o_overtemp_alert_n && o_second_overtemp_alert_n)
    else $error("alert active after reset");
endmodule : mtr_readout

// file: mtr_diode_model.sv
// Purpose: converter and remote junction model facing the readout
// Assumes: fixed conversion latency, all pins driven on i_mclk
// Notes: count bus shows inverted data outside the done cycle
module mtr_diode_model
  import mtr_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // from the readout
  input wire logic i_start,
  input wire logic [3:0] i_ch,
  // junction settings per channel
  input wire logic [MTR_NCH*13-1:0] i_temp,
  input wire logic [MTR_NCH-1:0] i_fault,
  input wire logic [MTR_NCH-1:0] i_short,
  // to the readout
  output logic o_done,
  output logic [MTR_RAW_W-1:0] o_count,
  output logic o_fault,
  output logic o_short
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  logic [3:0] ch_q;
  // latency of ten cycles so the pin synchronisers settle before done
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cnt <= 0;
      ch_q <= 4'h0;
      o_done <= 1'b0;
      o_count <= 13'h0000;
      o_fault <= 1'b0;
      o_short <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        cnt <= 10;
        ch_q <= i_ch;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (cnt == 1) begin
        cnt <= 0;
        o_done <= 1'b1;
        o_count <= i_temp[int'(ch_q)*13 +: 13];
      end else if (o_done) begin
        o_count <= ~o_count; // released bus must not hold its value
      end
      o_fault <= (cnt > 1) && i_fault[ch_q];
      o_short <= (cnt > 1) && i_short[ch_q];
    end
  end
endmodule : mtr_diode_model

// file: mtr_readout_tb.sv
// Purpose: self-checking bench for the nine channel readout
// Assumes: converter model answers every start after ten cycles
// Notes: eleven done pulses are taken as one full sweep
module mtr_readout_tb;
  import mtr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, shut, clr, start, busy, alert_n, alert2_n, done, fpin, spin;
  logic [15:0] hyst;
  logic [143:0] lim1, lim2, result;
  logic [116:0] temp;
  logic [8:0] fault, short, flags;
  logic [3:0] ch;
  logic [12:0] count;
  int fail_count, checks, cycles, n;
  logic [12:0] tcnt[9] = '{13'h0001, 13'h1FFF, 13'h0190, 13'h1000, 13'h0FFF,
                           13'h1C00, 13'h1E70, 13'h0320, 13'h0BF0};
  logic [15:0] tword[9] = '{16'h0008, 16'hFFF8, 16'h0C80, 16'h8000, 16'h7FF8,
                            16'hE000, 16'hF380, 16'h1900, 16'h5F80};
  logic [12:0] acnt[6] = '{13'h04B0, 13'h02D0, 13'h06E0, 13'h05F0, 13'h0550, 13'h01E0};
  logic [1:0] aexp[6] = '{2'b10, 2'b10, 2'b00, 2'b00, 2'b10, 2'b11};
  mtr_readout #(.NCH(MTR_NCH)) i_mtr_readout (.i_mclk(mclk), .i_rst(rst),
    .i_shutdown_control_bit(shut), .i_hyst(hyst), .i_limit1(lim1), .i_limit2(lim2),
    .i_open_flag_clr(clr), .i_conv_done(done), .i_conv_count(count), .i_fault_cmp(fpin),
    .i_diode_short(spin), .o_conv_start(start), .o_conv_ch(ch), .o_busy(busy),
    .o_result(result), .o_remote_open_flag(flags), .o_overtemp_alert_n(alert_n),
    .o_second_overtemp_alert_n(alert2_n));
  mtr_diode_model i_mtr_diode_model (.i_mclk(mclk), .i_rst(rst), .i_start(start),
    .i_ch(ch), .i_temp(temp), .i_fault(fault), .i_short(short), .o_done(done),
    .o_count(count), .o_fault(fpin), .o_short(spin));
  // free-running clock, 4 ns period
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic end_of_test;
    if (fail_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word
  task automatic cmp_bits(input string what, input logic [8:0] exp, input logic [8:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_bits
  // waits until every channel has been converted again, plus alert latency
  task automatic sweep;
    n = 0;
    while (n < 11) begin
      @(posedge mclk);
      if (done === 1'b1) n++;
    end
    repeat (4) @(posedge mclk);
  endtask : sweep
  // hang guard, far above the roughly 1900 cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    rst = 1'b1;
    shut = 1'b0;
    clr = 1'b0;
    hyst = 16'h0500;
    fault = 9'h000;
    short = 9'h000;
    lim1 = {9{16'h7FF8}};
    lim2 = {9{16'h7FF8}};
    lim1[47:32] = 16'h1900;
    lim2[47:32] = 16'h3200;
    for (int i = 0; i < 9; i++) temp[i*13 +: 13] = tcnt[i];
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    sweep();
    for (int i = 0; i < 9; i++) cmp_word("result", tword[i], result[i*16 +: 16]);
    cmp_bits("alerts at limit", 9'h003, {7'h00, alert2_n, alert_n});
    cmp_bits("idle start", 9'h000, {8'h00, start});
    cmp_bits("channel range", 9'h001, {8'h00, ch <= 4'h8});
    // shorted remote reads minus 256, local short ignored
    temp[0 +: 13] <= 13'h0190;
    temp[39 +: 13] <= 13'h0190;
    short <= 9'h009;
    sweep();
    cmp_word("short ch3", 16'h8000, result[63:48]);
    cmp_word("short ch0", 16'h0C80, result[15:0]);
    short <= 9'h000;
    fault <= 9'h021;
    sweep();
    cmp_bits("open flags", 9'h020, flags);
    fault <= 9'h000;
    sweep();
    cmp_bits("sticky flags", 9'h020, flags);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    repeat (3) @(posedge mclk);
    cmp_bits("cleared flags", 9'h000, flags);
    // hysteresis walk on channel 2 across both limits
    for (int k = 0; k < 6; k++) begin
      temp[26 +: 13] <= acnt[k];
      sweep();
      cmp_bits("alerts", {7'h00, aexp[k]}, {7'h00, alert2_n, alert_n});
    end
    shut <= 1'b1;
    repeat (40) @(posedge mclk);
    cmp_bits("busy in shutdown", 9'h000, {8'h00, busy});
    temp[26 +: 13] <= 13'h0320;
    n = 0;
    repeat (60) begin
      @(posedge mclk);
      if (start !== 1'b0) n++;
    end
    cmp_bits("starts in shutdown", 9'h000, n[8:0]);
    cmp_word("frozen ch2", 16'h0F00, result[47:32]);
    shut <= 1'b0;
    sweep();
    cmp_word("resumed ch2", 16'h1900, result[47:32]);
    end_of_test();
  end
endmodule : mtr_readout_tb
